/* rtl/pmcs_pkg.sv */
/*
 * Shared types and constants of the power mode and clock supervisor.
 * Assumes a single 10 MHz clock domain and no register bus.
 */
package pmcs_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS       = 100;
   localparam int REG_SETTLE_NS       = 500;   // Regulator main-mode settle time
   localparam int REG_SETTLE_CYC      = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CSS_TIMEOUT_NS      = 2000;  // External clock silence before failure
   localparam int CSS_TIMEOUT_CYC     = CSS_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W               = 8;
   localparam int EXT_LINES           = 16;
   localparam int BUS_MAX_MHZ         = 48;
   localparam int PRE_W               = 3;

   localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
   localparam logic [PRE_W-1:0] PRE_ZERO  = 3'h0;

   // ****************************************************************
   // Modes and sources
   // ****************************************************************
   typedef enum logic [2:0] {
      PM_RESET,
      PM_RUN,
      PM_SLEEP,
      PM_STOP,
      PM_STOP_WAKE_REG,
      PM_STANDBY
   } pmcs_mode_e;

   typedef enum logic [1:0] {
      CLK_INTERNAL_RC = 2'h0,
      CLK_EXTERNAL    = 2'h1,
      CLK_PLL         = 2'h2
   } pmcs_clk_e;

   // Low-power request from the CPU
   typedef enum logic [1:0] {
      REQ_NONE    = 2'h0,
      REQ_SLEEP   = 2'h1,
      REQ_STOP    = 2'h2,
      REQ_STANDBY = 2'h3
   } pmcs_req_e;

   // Supply monitor inputs
   typedef struct packed {
      logic main_ok;          // Main supply above reset threshold
      logic analog_ok;        // Analog supply above reset threshold
      logic detector_above;   // Main supply above detector threshold
   } pmcs_supply_s;

   // Wakeup sources
   typedef struct packed {
      logic [EXT_LINES-1:0] ext_pin;
      logic                 rtc_event;
      logic                 two_wire;
      logic                 serial;
      logic                 comparators;
      logic                 cec;
      logic                 wakeup_pin;
      logic                 watchdog_reset;
      logic                 reset_pin;
   } pmcs_wake_s;

   // Domain controls driven out
   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic core_pwr_en;
      logic reg_enable;
      logic reg_low_power;
      logic pll_en;
      logic rc_en;
      logic xtal_en;
      logic rtc_wdg_clk_en;
   } pmcs_ctrl_s;

endpackage

/* rtl/pmcs_edge.sv */
/*
 * Rising/falling edge detector with a registered pulse output.
 * Assumes the input is synchronous to the clock.
 */
`timescale 1ns/10ps
module pmcs_edge (
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Level in, pulses out
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);
   import pmcs_pkg::*;

   typedef struct packed {
      logic armed;
      logic prev;
      logic rise;
      logic fall;
   } pmcs_edge_s;

   pmcs_edge_s st_r;
   pmcs_edge_s st_nxt;

   // Next state; the first sample after reset only primes the history,
   // so a pin idling high gives no false edge
   always_comb begin
      st_nxt       = st_r;
      st_nxt.armed = 1'b1;
      st_nxt.prev  = level_i;
      st_nxt.rise  = level_i & ~st_r.prev & st_r.armed;
      st_nxt.fall  = ~level_i & st_r.prev & st_r.armed;
   end

   // State register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise_o = st_r.rise;
   assign fall_o = st_r.fall;
endmodule // pmcs_edge

/* rtl/pmcs_supervisor.sv */
/*
 * Power mode and clock supervisor: supply reset, threshold detector,
 * regulator state, Sleep/Stop/Standby sequencing and clock failover.
 * Assumes all inputs synchronous to clock_i; control bits are ports.
 */
// Notes on behaviour
// - Chip reset is held while the main supply is below threshold.
// - Power-on and power-down both watch main and also analog unless disabled.
// - The enabled detector flags falling, rising or both crossings.
// - Regulator is on after reset, main mode in Run, optionally low power in Stop.
// - Standby turns the regulator off and removes core power.
// - Sleep halts only the CPU clock; wakeup on any interrupt or event.
// - Stop gates core clocks and disables PLL, RC and crystal.
// - Any external interrupt line source wakes the device from Stop.
// - A peripheral RC request in low-power Stop first restores main regulator mode.
// - Standby exits on reset pin, watchdog reset, wakeup pin rise or RTC event.
// - In Standby only the RTC domain stays powered; oscillators are off.
// - RTC, watchdog and their clocks keep running in Stop and Standby.
// - Reset selects the internal RC oscillator as CPU clock.
// - A failed external clock in Run falls back to the RC with optional interrupt.
// - Bus prescalers keep both bus clocks at or below 48 MHz.
`timescale 1ns/10ps
module pmcs_supervisor #(
   parameter int SYSCLK_MHZ = 48
) (
   // Clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 rst_n_i,
   // Supplies and options
   input  wire pmcs_pkg::pmcs_supply_s supply_i,
   input  wire logic                 analog_sup_dis_i,
   // Detector control
   input  wire logic                 detector_en_i,
   input  wire logic                 detector_fall_en_i,
   input  wire logic                 detector_rise_en_i,
   input  wire logic                 detector_clr_i,
   // Power mode control
   input  wire pmcs_pkg::pmcs_req_e  lp_req_i,
   input  wire logic                 stop_low_power_i,
   input  wire logic                 cpu_wake_i,
   input  wire pmcs_pkg::pmcs_wake_s wake_i,
   input  wire logic                 rc_req_i,
   // Clock control
   input  wire pmcs_pkg::pmcs_clk_e  clk_sel_i,
   input  wire logic                 ext_clk_tick_i,
   input  wire logic                 css_irq_en_i,
   input  wire logic                 css_clr_i,
   input  wire logic [pmcs_pkg::PRE_W-1:0] bus_pre_i,
   input  wire logic [pmcs_pkg::PRE_W-1:0] periph_pre_i,
   // Outputs
   output logic                      chip_reset_n_o,
   output logic                      detector_flag_o,
   output logic                      css_flag_o,
   output logic                      css_irq_o,
   output pmcs_pkg::pmcs_mode_e      mode_o,
   output pmcs_pkg::pmcs_ctrl_s      ctrl_o,
   output pmcs_pkg::pmcs_clk_e       clk_src_o,
   output logic                      rc_to_periph_o,
   output logic [pmcs_pkg::PRE_W-1:0] bus_pre_o,
   output logic [pmcs_pkg::PRE_W-1:0] periph_pre_o
);
   import pmcs_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      pmcs_mode_e        mode;
      logic              chip_reset_n;
      logic              det_flag;
      logic              css_flag;
      logic              css_irq;
      pmcs_ctrl_s        ctrl;
      pmcs_clk_e         clk_src;
      logic              rc_to_periph;
      logic [CNT_W-1:0]  settle_cnt;
      logic [CNT_W-1:0]  css_cnt;
      logic [PRE_W-1:0]  bus_pre;
      logic [PRE_W-1:0]  periph_pre;
   } pmcs_state_s;

   pmcs_state_s st_r;
   pmcs_state_s st_nxt;

   logic det_rise;
   logic det_fall;
   logic wk_rise;
   logic wk_fall_unused;
   logic supply_good;
   logic stop_wake;
   logic standby_wake;

   // ****************************************************************
   // Edge detectors
   // ****************************************************************
   pmcs_edge u_det_edge (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .level_i (supply_i.detector_above),
      .rise_o  (det_rise),
      .fall_o  (det_fall)
   );

   pmcs_edge u_wkpin_edge (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .level_i (wake_i.wakeup_pin),
      .rise_o  (wk_rise),
      .fall_o  (wk_fall_unused)
   );

   // Supply checks and wake qualifiers
   assign supply_good  = supply_i.main_ok &
                         (analog_sup_dis_i | supply_i.analog_ok);
   assign stop_wake    = (|wake_i.ext_pin) | det_rise | det_fall | wake_i.rtc_event |
                         wake_i.two_wire | wake_i.serial | wake_i.comparators |
                         wake_i.cec;
   assign standby_wake = wake_i.reset_pin | wake_i.watchdog_reset | wk_rise |
                         wake_i.rtc_event;

   // ****************************************************************
   // Divided frequency check for prescalers
   // ****************************************************************
   function automatic logic [PRE_W-1:0] legal_pre(input logic [PRE_W-1:0] p);
      logic [PRE_W-1:0] q;
      q = p;
      while ((SYSCLK_MHZ >> q) > BUS_MAX_MHZ) begin
         q = q + 3'h1;
      end
      return q;
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.ctrl.rtc_wdg_clk_en = 1'b1;
      st_nxt.bus_pre    = legal_pre(bus_pre_i);
      st_nxt.periph_pre = legal_pre(periph_pre_i);

      // Supply detector flags; set wins over clear
      if (detector_clr_i) begin
         st_nxt.det_flag = 1'b0;
      end
      if (detector_en_i && ((det_fall && detector_fall_en_i) ||
                            (det_rise && detector_rise_en_i))) begin
         st_nxt.det_flag = 1'b1;
      end

      // Clock security: count cycles without an external tick
      if (css_clr_i) begin
         st_nxt.css_flag = 1'b0;
      end
      if (st_r.clk_src == CLK_EXTERNAL && st_r.mode == PM_RUN) begin
         if (ext_clk_tick_i) begin
            st_nxt.css_cnt = CNT_ZERO;
         end else if (st_r.css_cnt >= CNT_W'(CSS_TIMEOUT_CYC)) begin
            st_nxt.clk_src  = CLK_INTERNAL_RC;
            st_nxt.css_flag = 1'b1;
            st_nxt.css_cnt  = CNT_ZERO;
         end else begin
            st_nxt.css_cnt = st_r.css_cnt + CNT_ONE;
         end
      end else begin
         st_nxt.css_cnt = CNT_ZERO;
         // A failed crystal is not taken back until its flag is cleared
         if (st_r.mode == PM_RUN && !(st_r.css_flag && clk_sel_i == CLK_EXTERNAL)) begin
            st_nxt.clk_src = clk_sel_i;
         end
      end
      st_nxt.css_irq = st_nxt.css_flag & css_irq_en_i;

      // Power mode sequencer
      case (st_r.mode)
         PM_RESET: begin
            st_nxt.chip_reset_n = 1'b0;
            st_nxt.clk_src      = CLK_INTERNAL_RC;
            st_nxt.ctrl         = '{cpu_clk_en: 1'b0, core_clk_en: 1'b0, core_pwr_en: 1'b1,
                                    reg_enable: 1'b1, reg_low_power: 1'b0, pll_en: 1'b0,
                                    rc_en: 1'b1, xtal_en: 1'b0, rtc_wdg_clk_en: 1'b1};
            if (supply_i.main_ok) begin
               st_nxt.mode         = PM_RUN;
               st_nxt.chip_reset_n = 1'b1;
               st_nxt.ctrl.cpu_clk_en  = 1'b1;
               st_nxt.ctrl.core_clk_en = 1'b1;
            end
         end
         PM_RUN: begin
            st_nxt.ctrl.cpu_clk_en    = 1'b1;
            st_nxt.ctrl.core_clk_en   = 1'b1;
            st_nxt.ctrl.reg_low_power = 1'b0;
            st_nxt.ctrl.pll_en  = (clk_sel_i == CLK_PLL);
            st_nxt.ctrl.xtal_en = (clk_sel_i != CLK_INTERNAL_RC);
            st_nxt.ctrl.rc_en   = 1'b1;
            case (lp_req_i)
               REQ_SLEEP: begin
                  st_nxt.mode            = PM_SLEEP;
                  st_nxt.ctrl.cpu_clk_en = 1'b0;
               end
               REQ_STOP: begin
                  st_nxt.mode               = PM_STOP;
                  st_nxt.ctrl.cpu_clk_en    = 1'b0;
                  st_nxt.ctrl.core_clk_en   = 1'b0;
                  st_nxt.ctrl.pll_en        = 1'b0;
                  st_nxt.ctrl.rc_en         = 1'b0;
                  st_nxt.ctrl.xtal_en       = 1'b0;
                  st_nxt.ctrl.reg_low_power = stop_low_power_i;
               end
               REQ_STANDBY: begin
                  st_nxt.mode             = PM_STANDBY;
                  st_nxt.ctrl.cpu_clk_en  = 1'b0;
                  st_nxt.ctrl.core_clk_en = 1'b0;
                  st_nxt.ctrl.reg_enable  = 1'b0;
                  st_nxt.ctrl.core_pwr_en = 1'b0;
                  st_nxt.ctrl.pll_en      = 1'b0;
                  st_nxt.ctrl.rc_en       = 1'b0;
                  st_nxt.ctrl.xtal_en     = 1'b0;
               end
               default: begin
               end
            endcase
         end
         PM_SLEEP: begin
            if (cpu_wake_i || stop_wake) begin
               st_nxt.mode            = PM_RUN;
               st_nxt.ctrl.cpu_clk_en = 1'b1;
            end
         end
         PM_STOP: begin
            if (stop_wake) begin
               st_nxt.mode               = PM_RUN;
               st_nxt.clk_src            = CLK_INTERNAL_RC;
               st_nxt.ctrl.reg_low_power = 1'b0;
               st_nxt.ctrl.rc_en         = 1'b1;
               st_nxt.ctrl.cpu_clk_en    = 1'b1;
               st_nxt.ctrl.core_clk_en   = 1'b1;
               st_nxt.rc_to_periph       = 1'b0;
            end else if (rc_req_i && !st_r.rc_to_periph) begin
               if (st_r.ctrl.reg_low_power) begin
                  st_nxt.mode               = PM_STOP_WAKE_REG;
                  st_nxt.ctrl.reg_low_power = 1'b0;
                  st_nxt.settle_cnt         = CNT_W'(REG_SETTLE_CYC);
               end else begin
                  st_nxt.ctrl.rc_en   = 1'b1;
                  st_nxt.rc_to_periph = 1'b1;
               end
            end else if (!rc_req_i && st_r.rc_to_periph) begin
               st_nxt.rc_to_periph       = 1'b0;
               st_nxt.ctrl.rc_en         = 1'b0;
               st_nxt.ctrl.reg_low_power = stop_low_power_i;
            end
         end
         PM_STOP_WAKE_REG: begin
            if (st_r.settle_cnt <= CNT_ONE) begin
               st_nxt.mode         = PM_STOP;
               st_nxt.settle_cnt   = CNT_ZERO;
               st_nxt.ctrl.rc_en   = 1'b1;
               st_nxt.rc_to_periph = 1'b1;
            end else begin
               st_nxt.settle_cnt = st_r.settle_cnt - CNT_ONE;
            end
         end
         PM_STANDBY: begin
            st_nxt.chip_reset_n = 1'b0;
            if (standby_wake) begin
               st_nxt.mode = PM_RESET;
            end
         end
         default: begin
            st_nxt.mode = PM_RESET;
         end
      endcase

      // Supply loss overrides everything except Standby
      if (!supply_good && st_r.mode != PM_STANDBY) begin
         st_nxt.mode         = PM_RESET;
         st_nxt.chip_reset_n = 1'b0;
         st_nxt.rc_to_periph = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '{mode: PM_RESET, chip_reset_n: 1'b0, det_flag: 1'b0, css_flag: 1'b0,
                   css_irq: 1'b0,
                   ctrl: '{cpu_clk_en: 1'b0, core_clk_en: 1'b0, core_pwr_en: 1'b1,
                           reg_enable: 1'b1, reg_low_power: 1'b0, pll_en: 1'b0,
                           rc_en: 1'b1, xtal_en: 1'b0, rtc_wdg_clk_en: 1'b1},
                   clk_src: CLK_INTERNAL_RC, rc_to_periph: 1'b0, settle_cnt: CNT_ZERO,
                   css_cnt: CNT_ZERO, bus_pre: PRE_ZERO, periph_pre: PRE_ZERO};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign chip_reset_n_o  = st_r.chip_reset_n;
   assign detector_flag_o = st_r.det_flag;
   assign css_flag_o      = st_r.css_flag;
   assign css_irq_o       = st_r.css_irq;
   assign mode_o          = st_r.mode;
   assign ctrl_o          = st_r.ctrl;
   assign clk_src_o       = st_r.clk_src;
   assign rc_to_periph_o  = st_r.rc_to_periph;
   assign bus_pre_o       = st_r.bus_pre;
   assign periph_pre_o    = st_r.periph_pre;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   supply_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !supply_i.main_ok |=> !chip_reset_n_o)
      else $error("chip not held in reset on low supply");

   analog_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!supply_i.analog_ok && !analog_sup_dis_i && mode_o != PM_STANDBY)
      |=> !chip_reset_n_o)
      else $error("analog supply loss ignored");

   detector_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (detector_en_i && detector_fall_en_i && det_fall) |=> detector_flag_o)
      else $error("detector fall not flagged");

   run_main_reg_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      mode_o == PM_RUN |-> (ctrl_o.reg_enable && !ctrl_o.reg_low_power))
      else $error("regulator not in main mode in run");

   standby_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      mode_o == PM_STANDBY |-> (!ctrl_o.reg_enable && !ctrl_o.core_pwr_en
                                && !ctrl_o.rc_en && !ctrl_o.xtal_en))
      else $error("core powered in standby");

   stop_gated_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(mode_o == PM_STOP) && $past(mode_o) == PM_RUN
      |-> (!ctrl_o.core_clk_en && !ctrl_o.pll_en && !ctrl_o.xtal_en))
      else $error("stop entry left clocks running");

   rc_needs_main_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(rc_to_periph_o) |-> !ctrl_o.reg_low_power)
      else $error("rc delivered on low power regulator");

   rtc_running_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ctrl_o.rtc_wdg_clk_en)
      else $error("rtc clock stopped");

   css_fallback_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(css_flag_o) |-> clk_src_o == CLK_INTERNAL_RC)
      else $error("no fallback on clock failure");
endmodule // pmcs_supervisor

/* test/pmcs_osc_model.sv */
/*
 * External oscillator model: one tick every other clock while it runs.
 * Assumes the bench starts and stops it to mimic a failing crystal.
 */
`timescale 1ns/10ps
module pmcs_osc_model (
   // Clock
   input  wire logic clock_i,
   // Control
   input  wire logic run_i,
   // Tick out
   output logic      tick_o
);
   logic phase_r = 1'b0;

   // Ticks move just after the rising edge; a stopped crystal gives no ticks
   always @(posedge clock_i) begin
      phase_r <= ~phase_r;
      tick_o  <= run_i & phase_r;
   end
endmodule // pmcs_osc_model

/* test/pmcs_supervisor_tb_top.sv */
/*
 * Self-checking bench of the supervisor, one task for each scenario.
 * Assumes pmcs_pkg and the oscillator model are compiled before it.
 */
`timescale 1ns/10ps
module pmcs_supervisor_tb_top;
   import pmcs_pkg::*;
   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic              clock = 1'b0, rst_n = 1'b0, ana_dis = 1'b0, osc_run = 1'b0;
   logic              det_en = 1'b0, fall_en = 1'b0, rise_en = 1'b0, det_clr = 1'b0;
   logic              stop_lp = 1'b0, cpu_wake = 1'b0, rc_req = 1'b0;
   logic              css_en = 1'b0, css_clr = 1'b0, tick;
   logic [PRE_W-1:0]  bus_pre = 3'h1, per_pre = 3'h1, bus_pre_q, per_pre_q;
   pmcs_supply_s      supply = 3'h7;
   pmcs_req_e         lp_req = REQ_NONE;
   pmcs_wake_s        wake = '0;
   pmcs_clk_e         clk_sel = CLK_INTERNAL_RC, clk_src;
   pmcs_mode_e        mode;
   pmcs_ctrl_s        ctrl;
   logic              chip_rst_n, det_flag, css_flag, css_irq, rc_out;
   int                mismatches = 0, checked = 0, cycles = 0;
   int                src [4] = '{0, 1, 2, 7};

   pmcs_osc_model osc (.clock_i(clock), .run_i(osc_run), .tick_o(tick));

   pmcs_supervisor #(.SYSCLK_MHZ(96)) uut (
      .clock_i(clock), .rst_n_i(rst_n), .supply_i(supply), .analog_sup_dis_i(ana_dis),
      .detector_en_i(det_en), .detector_fall_en_i(fall_en), .detector_rise_en_i(rise_en),
      .detector_clr_i(det_clr), .lp_req_i(lp_req), .stop_low_power_i(stop_lp),
      .cpu_wake_i(cpu_wake), .wake_i(wake), .rc_req_i(rc_req), .clk_sel_i(clk_sel),
      .ext_clk_tick_i(tick), .css_irq_en_i(css_en), .css_clr_i(css_clr),
      .bus_pre_i(bus_pre), .periph_pre_i(per_pre), .chip_reset_n_o(chip_rst_n),
      .detector_flag_o(det_flag), .css_flag_o(css_flag), .css_irq_o(css_irq),
      .mode_o(mode), .ctrl_o(ctrl), .clk_src_o(clk_src), .rc_to_periph_o(rc_out),
      .bus_pre_o(bus_pre_q), .periph_pre_o(per_pre_q));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wait_mode(input pmcs_mode_e m);
      for (int i = 0; i < 12 && mode !== m; i++) cyc(1);
   endtask
   task automatic wait_up;
      for (int i = 0; i < 12 && chip_rst_n !== 1'b1; i++) cyc(1);
      cyc(2);
   endtask
   task automatic enter(input pmcs_req_e r);
      lp_req = r;
      cyc(1);
      lp_req = REQ_NONE;
      cyc(1);
   endtask
   task automatic pulse(input int b);
      wake = pmcs_wake_s'(24'h1 << b);
      cyc(1);
      wake = '0;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      chk(chip_rst_n, 1'b1);
      chk(clk_src, CLK_INTERNAL_RC);
      chk(ctrl.reg_enable, 1'b1);
      chk(ctrl.reg_low_power, 1'b0);
      supply.analog_ok = 1'b0;
      cyc(3);
      chk(chip_rst_n, 1'b0);
      supply.analog_ok = 1'b1;
      wait_up();
      ana_dis = 1'b1;
      supply.analog_ok = 1'b0;
      cyc(3);
      chk(chip_rst_n, 1'b1);
      supply = 3'h3;
      cyc(3);
      chk(chip_rst_n, 1'b0);
      supply = 3'h7;
      ana_dis = 1'b0;
      wait_up();
      chk(mode, PM_RUN);
      $display("test supply reset done");
   endtask
   task automatic t_det;
      det_en = 1'b1;
      fall_en = 1'b1;
      supply.detector_above = 1'b0;
      cyc(3);
      chk(det_flag, 1'b1);
      det_clr = 1'b1;
      cyc(1);
      det_clr = 1'b0;
      fall_en = 1'b0;
      supply.detector_above = 1'b1;
      cyc(3);
      chk(det_flag, 1'b0);
      rise_en = 1'b1;
      supply.detector_above = 1'b0;
      cyc(3);
      chk(det_flag, 1'b0);
      supply.detector_above = 1'b1;
      cyc(3);
      chk(det_flag, 1'b1);
      det_clr = 1'b1;
      cyc(1);
      det_clr = 1'b0;
      $display("test detector done");
   endtask
   task automatic t_sleep;
      enter(REQ_SLEEP);
      chk(mode, PM_SLEEP);
      chk(ctrl.cpu_clk_en, 1'b0);
      chk(ctrl.core_clk_en, 1'b1);
      cpu_wake = 1'b1;
      cyc(1);
      cpu_wake = 1'b0;
      wait_mode(PM_RUN);
      chk(ctrl.cpu_clk_en, 1'b1);
      $display("test sleep done");
   endtask
   task automatic t_stop;
      for (int i = 3; i < 24; i++) begin
         enter(REQ_STOP);
         chk(mode, PM_STOP);
         chk({ctrl.core_clk_en, ctrl.pll_en, ctrl.rc_en, ctrl.xtal_en}, 4'h0);
         chk(ctrl.rtc_wdg_clk_en, 1'b1);
         pulse(i);
         wait_mode(PM_RUN);
         chk(mode, PM_RUN);
      end
      $display("test stop wakeup done");
   endtask
   task automatic t_stop_rc;
      stop_lp = 1'b1;
      enter(REQ_STOP);
      chk(ctrl.reg_low_power, 1'b1);
      rc_req = 1'b1;
      cyc(3);
      chk(rc_out, 1'b0);
      cyc(REG_SETTLE_CYC);
      chk(rc_out, 1'b1);
      chk(ctrl.reg_low_power, 1'b0);
      rc_req = 1'b0;
      stop_lp = 1'b0;
      pulse(8);
      wait_mode(PM_RUN);
      $display("test stop clock request done");
   endtask
   task automatic t_standby;
      foreach (src[k]) begin
         enter(REQ_STANDBY);
         chk({ctrl.reg_enable, ctrl.core_pwr_en}, 2'h0);
         chk({ctrl.pll_en, ctrl.rc_en, ctrl.xtal_en}, 3'h0);
         chk(ctrl.rtc_wdg_clk_en, 1'b1);
         pulse(8);
         cyc(3);
         chk(mode, PM_STANDBY);
         pulse(src[k]);
         wait_mode(PM_RUN);
         chk(mode, PM_RUN);
      end
      $display("test standby done");
   endtask
   task automatic t_css;
      osc_run = 1'b1;
      css_en = 1'b1;
      clk_sel = CLK_EXTERNAL;
      cyc(3);
      chk(clk_src, CLK_EXTERNAL);
      osc_run = 1'b0;
      cyc(CSS_TIMEOUT_CYC - 3);
      chk(clk_src, CLK_EXTERNAL);
      cyc(7);
      chk({clk_src, css_flag, css_irq}, {CLK_INTERNAL_RC, 2'h3});
      clk_sel = CLK_INTERNAL_RC;
      css_clr = 1'b1;
      cyc(1);
      css_clr = 1'b0;
      cyc(1);
      chk({css_flag, css_irq}, 2'h0);
      $display("test clock failover done");
   endtask
   task automatic t_pre;
      bus_pre = PRE_ZERO;
      per_pre = PRE_ZERO;
      cyc(2);
      chk({bus_pre_q, per_pre_q}, 6'h09);
      bus_pre = 3'h2;
      per_pre = 3'h3;
      cyc(2);
      chk({bus_pre_q, per_pre_q}, 6'h13);
      $display("test prescalers done");
   endtask
   // ****************************************************************
   // Clock, watchdog on the run and main sequence
   // ****************************************************************
   always #50 clock = ~clock;

   // Cuts a hang short well after the tests should be over
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end

   // Reset for four cycles, then every scenario in turn
   initial begin
      cyc(4);
      rst_n = 1'b1;
      cyc(3);
      t_reset();
      t_det();
      t_sleep();
      t_stop();
      t_stop_rc();
      t_standby();
      t_css();
      t_pre();
      conclude();
   end
endmodule // pmcs_supervisor_tb_top
